// ===== shared/dpl_params.svh
// Purpose: constants of the dual pixel lane serializer
// Assumes: included by bare name
// Notes: config vector packs the static option pins
`ifndef DPL_PARAMS_SVH
`define DPL_PARAMS_SVH
`define DPL_LANE_BITS 7
`define DPL_LAST_BIT 3'h6
`define DPL_LANES 10
`define DPL_GRP_LANES 5
`define DPL_GRP_W 35
`define DPL_WORD_W 70
`define DPL_PIX_W 30
`define DPL_CLR_W 10
`define DPL_FIFO_DEPTH 16
`define DPL_FIFO_AW 4
`define DPL_PIPE_SLACK 5
`define DPL_TRIM_TAPS 3
`define DPL_FCLK_MIN_MHZ 8
`define DPL_FCLK_MAX_MHZ 135
`define DPL_CLK_MHZ 10
`define DPL_LANE_MBPS_MAX (`DPL_FCLK_MAX_MHZ * `DPL_LANE_BITS)
`define DPL_CLK_LANE_PAT 7'h63
`define DPL_MASK_30 10'h3ff
`define DPL_MASK_24 10'h3fc
`define DPL_MASK_18 10'h3f0
`define DPL_CFG_W 13
`define DPL_CFG_EDGE 0
`define DPL_CFG_DUAL 1
`define DPL_CFG_DEPTH 3:2
`define DPL_CFG_TRIM 5:4
`define DPL_CFG_INDIS 7:6
`define DPL_CFG_OUTDIS 9:8
`define DPL_CFG_SWING 10
`define DPL_CFG_OFFS 12:11
`endif

// ===== shared/dpl_pkg.sv
// Purpose: types of the dual pixel lane serializer
// Assumes: nothing
// Notes: depth code 2'h3 behaves as 30-bit
package dpl_pkg;
  typedef enum logic [1:0] {
    DPL_D30 = 2'b00,
    DPL_D24 = 2'b01,
    DPL_D18 = 2'b10
  } dpl_depth_t;
  typedef enum logic [0:0] {
    DPL_HS_IDLE = 1'b0,
    DPL_HS_WAIT = 1'b1
  } dpl_hs_t;
endpackage

// ===== src/dpl_fifo.sv
// Purpose: word buffer between capture and link handoff
// Assumes: single clock, writer honours wr_ready_out
// Notes: level_out lets the writer keep slack for its pipeline
`timescale 1ns/100ps
`default_nettype none
`include "dpl_params.svh"
module dpl_fifo
  import dpl_pkg::*;
#(
  parameter int W = `DPL_WORD_W,
  parameter int D = `DPL_FIFO_DEPTH,
  parameter int AW = `DPL_FIFO_AW
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // Fill side
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [W-1:0] wr_data_in,
  // Drain side
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [W-1:0] rd_data_out,
  output logic [AW:0] level_out
);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } dpl_fifo_st_t;
  dpl_fifo_st_t s, next_s;
  logic push, pop;
  assign wr_ready_out = (s.cnt != (AW+1)'(D));
  assign rd_valid_out = (s.cnt != '0);
  assign rd_data_out = s.mem[s.rp];
  assign level_out = s.cnt;
  always_comb begin
    next_s = s;
    push = wr_valid_in & wr_ready_out;
    pop = rd_valid_out & rd_ready_in;
    if (ce_in) begin
      if (push) begin
        next_s.mem[s.wp] = wr_data_in;
        next_s.wp = s.wp + 1'b1;
      end
      if (pop) begin
        next_s.rp = s.rp + 1'b1;
      end
      case ({push, pop})
        2'b10: next_s.cnt = s.cnt + 1'b1;
        2'b01: next_s.cnt = s.cnt - 1'b1;
        default: next_s.cnt = s.cnt;
      endcase
    end
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// ===== src/dpl_link_ser.sv
// Purpose: seven-to-one lane serializer on the link clock
// Assumes: word_in stays stable while req_tgl_in differs from ack
// Notes: an empty frame sends zeros, clock lane keeps running
`timescale 1ns/100ps
`default_nettype none
`include "dpl_params.svh"
module dpl_link_ser
  import dpl_pkg::*;
(
  // Link clock, reset, enable from the core domain
  input wire logic link_clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // Word handshake
  input wire logic req_tgl_in,
  input wire logic [`DPL_WORD_W-1:0] word_in,
  output logic ack_tgl_out,
  // Serial lanes
  output logic [`DPL_LANES-1:0] lanes_out,
  output logic clk_lane_out
);
  localparam logic [6:0] PAT = `DPL_CLK_LANE_PAT;
  typedef struct packed {
    logic ce_s1;
    logic ce_s2;
    logic req_s1;
    logic req_s2;
    logic ack;
    logic [2:0] idx;
    logic [`DPL_WORD_W-1:0] shift;
    logic [`DPL_LANES-1:0] lanes;
    logic clk_lane;
  } dpl_ser_st_t;
  dpl_ser_st_t s, next_s;
  assign ack_tgl_out = s.ack;
  assign lanes_out = s.lanes;
  assign clk_lane_out = s.clk_lane;
  always_comb begin
    next_s = s;
    next_s.ce_s1 = ce_in;
    next_s.ce_s2 = s.ce_s1;
    next_s.req_s1 = req_tgl_in;
    next_s.req_s2 = s.req_s1;
    if (s.ce_s2) begin
      for (int k = 0; k < `DPL_LANES; k++) begin
        next_s.lanes[k] = s.shift[k*`DPL_LANE_BITS + 6 - int'(s.idx)];
      end
      next_s.clk_lane = PAT[3'(`DPL_LAST_BIT - s.idx)];
      if (s.idx == `DPL_LAST_BIT) begin
        next_s.idx = 3'h0;
        if (s.req_s2 != s.ack) begin
          next_s.shift = word_in;
          next_s.ack = s.req_s2;
        end else begin
          next_s.shift = '0;
        end
      end else begin
        next_s.idx = s.idx + 3'h1;
      end
    end
  end
  always_ff @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  default clocking @(posedge link_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence seq_new_word;
    s.ce_s2 && s.idx == `DPL_LAST_BIT && s.req_s2 != s.ack;
  endsequence
  chk_frame_wrap: assert property (s.ce_s2 && s.idx == `DPL_LAST_BIT |=> s.idx == 3'h0)
    else $error("frame did not wrap after seven bits");
  chk_clk_lane_high: assert property (s.ce_s2 && s.idx == 3'h0 |=> clk_lane_out)
    else $error("clock lane low at frame start");
  chk_clk_lane_low: assert property (s.ce_s2 && s.idx == 3'h3 |=> !clk_lane_out)
    else $error("clock lane high mid frame");
  chk_word_load: assert property (seq_new_word |=> ack_tgl_out == $past(s.req_s2)
    && s.shift == $past(word_in))
    else $error("word not loaded at frame boundary");
endmodule
`default_nettype wire

// ===== src/dpl_tx_core.sv
// Purpose: pixel capture and dual port lane transmitter core
// Assumes: pixels arrive on clk_in; option pins are static
// Notes: link side runs on link_clk_in, words cross by toggle handshake
`timescale 1ns/100ps
`default_nettype none
`include "dpl_params.svh"
module dpl_tx_core
  import dpl_pkg::*;
(
  // Clocks, reset, enable
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic link_clk_in,
  // Pixel stream
  input wire logic pix_valid_in,
  output logic pix_ready_out,
  input wire logic [`DPL_PIX_W-1:0] pix_odd_rgb_in,
  input wire logic [`DPL_PIX_W-1:0] pix_even_rgb_in,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic data_enable_in,
  input wire logic [1:0] user_ctl_in,
  // Option pins
  input wire logic capture_edge_select_in,
  input wire logic dual_pixel_in,
  input wire logic [1:0] depth_sel_in,
  input wire logic [1:0] setup_trim_in,
  input wire logic [1:0] in_chan_disable_in,
  input wire logic [1:0] out_chan_disable_in,
  input wire logic reduced_swing_in,
  input wire logic [1:0] offset_level_in,
  // Panel side
  output logic [`DPL_GRP_LANES-1:0] first_port_lanes_out,
  output logic [`DPL_GRP_LANES-1:0] second_port_lanes_out,
  output logic link_clk_lane_out,
  output logic differential_swing_out,
  output logic [1:0] offset_level_out
);

  localparam int W = `DPL_WORD_W;
  localparam int G = `DPL_GRP_W;

  typedef struct packed {
    logic [`DPL_CFG_W-1:0] cfg_s1;
    logic [`DPL_CFG_W-1:0] cfg_s2;
    logic cap_v;
    logic [W-1:0] cap_w;
    logic [`DPL_TRIM_TAPS-1:0] dly_v;
    logic [`DPL_TRIM_TAPS-1:0][W-1:0] dly_w;
    dpl_hs_t hs;
    logic req;
    logic [W-1:0] xfer_w;
    logic ack_s1;
    logic ack_s2;
    logic swing;
    logic [1:0] offs;
  } dpl_core_st_t;

  dpl_core_st_t s, next_s;

  logic [`DPL_CFG_W-1:0] raw_cfg;
  logic [1:0] depth;
  logic [4:0] ctl_bits;
  logic [`DPL_PIX_W-1:0] rgb_odd;
  logic [`DPL_PIX_W-1:0] rgb_even;
  logic [G-1:0] grp_odd;
  logic [G-1:0] grp_even;
  logic [W-1:0] live_w;
  logic [W-1:0] neg_w;
  logic neg_v;
  logic sel_v;
  logic [W-1:0] sel_w;
  logic tap_v;
  logic [W-1:0] tap_w;
  logic fifo_wr_ready;
  logic fifo_rd_valid;
  logic fifo_rd_ready;
  logic [W-1:0] fifo_rd_data;
  logic [`DPL_FIFO_AW:0] fifo_level;
  logic fifo_push;
  logic fifo_pop;
  logic link_ack;
  logic [`DPL_LANES-1:0] lanes;

  // Colour bits below the chosen depth are forced to zero
  function automatic logic [`DPL_PIX_W-1:0] depth_mask(
    input logic [`DPL_PIX_W-1:0] rgb,
    input logic [1:0] dsel
  );
    logic [`DPL_CLR_W-1:0] m;
    case (dsel)
      DPL_D24: m = `DPL_MASK_24;
      DPL_D18: m = `DPL_MASK_18;
      default: m = `DPL_MASK_30;
    endcase
    return rgb & {m, m, m};
  endfunction

  // One port group: five lanes of seven bits
  function automatic logic [G-1:0] build_grp(
    input logic [`DPL_PIX_W-1:0] rgb,
    input logic [4:0] ctl,
    input logic [1:0] dsel
  );
    return {ctl, depth_mask(rgb, dsel)};
  endfunction

  assign raw_cfg = {offset_level_in, reduced_swing_in,
                    out_chan_disable_in, in_chan_disable_in,
                    setup_trim_in, depth_sel_in,
                    dual_pixel_in, capture_edge_select_in};
  assign depth = s.cfg_s2[`DPL_CFG_DEPTH];

  // Assemble the 70-bit word from the live inputs
  always_comb begin
    ctl_bits = {user_ctl_in, data_enable_in, vsync_in, hsync_in};
    rgb_odd = pix_odd_rgb_in;
    rgb_even = pix_even_rgb_in;
    if (s.cfg_s2[`DPL_CFG_INDIS][0]) begin
      rgb_odd = '0;
    end
    if (s.cfg_s2[`DPL_CFG_INDIS][1]) begin
      rgb_even = '0;
    end
    grp_odd = build_grp(rgb_odd, ctl_bits, depth);
    grp_even = '0;
    if (s.cfg_s2[`DPL_CFG_DUAL]) begin
      grp_even = build_grp(rgb_even, ctl_bits, depth);
    end
    if (s.cfg_s2[`DPL_CFG_OUTDIS][0]) begin
      grp_odd = '0;
    end
    if (s.cfg_s2[`DPL_CFG_OUTDIS][1]) begin
      grp_even = '0;
    end
    live_w = {grp_even, grp_odd};
  end

  // Falling-edge copy sits outside the state record on purpose:
  // it is the only negedge logic and serves the alternate strobe.
  always_ff @(negedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      neg_v <= 1'b0;
      neg_w <= '0;
    end else if (ce_in) begin
      neg_v <= pix_valid_in;
      neg_w <= live_w;
    end
  end

  // Capture edge choice
  always_comb begin
    if (s.cfg_s2[`DPL_CFG_EDGE]) begin
      sel_v = neg_v;
      sel_w = neg_w;
    end else begin
      sel_v = pix_valid_in;
      sel_w = live_w;
    end
  end

  // Trim picks a tap; valid travels with data so alignment holds
  always_comb begin
    case (s.cfg_s2[`DPL_CFG_TRIM])
      2'h1: begin
        tap_v = s.dly_v[0];
        tap_w = s.dly_w[0];
      end
      2'h2: begin
        tap_v = s.dly_v[1];
        tap_w = s.dly_w[1];
      end
      2'h3: begin
        tap_v = s.dly_v[2];
        tap_w = s.dly_w[2];
      end
      default: begin
        tap_v = s.cap_v;
        tap_w = s.cap_w;
      end
    endcase
  end

  // Slack covers capture plus delay taps still in flight
  assign pix_ready_out = fifo_level <
    (`DPL_FIFO_AW+1)'(`DPL_FIFO_DEPTH - `DPL_PIPE_SLACK);
  assign fifo_push = tap_v;
  assign fifo_rd_ready = (s.hs == DPL_HS_IDLE);
  assign fifo_pop = fifo_rd_valid & fifo_rd_ready & ce_in;

  always_comb begin
    next_s = s;
    if (ce_in) begin
      next_s.cfg_s1 = raw_cfg;
      next_s.cfg_s2 = s.cfg_s1;
      next_s.ack_s1 = link_ack;
      next_s.ack_s2 = s.ack_s1;
      next_s.cap_v = sel_v & pix_ready_out;
      if (sel_v & pix_ready_out) begin
        next_s.cap_w = sel_w;
      end
      next_s.dly_v = {s.dly_v[1:0], s.cap_v};
      next_s.dly_w = {s.dly_w[1:0], s.cap_w};
      next_s.swing = s.cfg_s2[`DPL_CFG_SWING];
      next_s.offs = s.cfg_s2[`DPL_CFG_OFFS];
      case (s.hs)
        DPL_HS_IDLE: begin
          if (fifo_rd_valid) begin
            next_s.xfer_w = fifo_rd_data;
            next_s.req = ~s.req;
            next_s.hs = DPL_HS_WAIT;
          end
        end
        DPL_HS_WAIT: begin
          if (s.ack_s2 == s.req) begin
            next_s.hs = DPL_HS_IDLE;
          end
        end
        default: next_s.hs = DPL_HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  dpl_fifo #(
    .W(W),
    .D(`DPL_FIFO_DEPTH),
    .AW(`DPL_FIFO_AW)
  ) u_fifo (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .wr_valid_in(fifo_push),
    .wr_ready_out(fifo_wr_ready),
    .wr_data_in(tap_w),
    .rd_valid_out(fifo_rd_valid),
    .rd_ready_in(fifo_rd_ready),
    .rd_data_out(fifo_rd_data),
    .level_out(fifo_level)
  );

  dpl_link_ser u_ser (
    .link_clk_in(link_clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .req_tgl_in(s.req),
    .word_in(s.xfer_w),
    .ack_tgl_out(link_ack),
    .lanes_out(lanes),
    .clk_lane_out(link_clk_lane_out)
  );

  assign first_port_lanes_out = lanes[`DPL_GRP_LANES-1:0];
  assign second_port_lanes_out = lanes[`DPL_LANES-1:`DPL_GRP_LANES];
  assign differential_swing_out = s.swing;
  assign offset_level_out = s.offs;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence seq_trim2_cap;
    s.cap_v && ce_in && s.cfg_s2[`DPL_CFG_TRIM] == 2'h2
    ##1 ce_in && s.cfg_s2[`DPL_CFG_TRIM] == 2'h2
    ##1 s.cfg_s2[`DPL_CFG_TRIM] == 2'h2;
  endsequence

  sequence seq_opt_steady;
    (ce_in && $stable(reduced_swing_in) && $stable(offset_level_in))[*4];
  endsequence

  chk_clk_range: assert property (`DPL_CLK_MHZ >= `DPL_FCLK_MIN_MHZ
    && `DPL_CLK_MHZ <= `DPL_FCLK_MAX_MHZ)
    else $error("pixel clock outside supported range");

  chk_single_grp: assert property (s.cap_v && !$past(s.cfg_s2[`DPL_CFG_DUAL])
    |-> s.cap_w[W-1:G] == '0)
    else $error("second port carries data in single mode");

  chk_dual_even: assert property (s.cap_v && $past(s.cfg_s2[`DPL_CFG_DUAL])
    && !$past(s.cfg_s2[`DPL_CFG_EDGE]) && $past(s.cfg_s2[`DPL_CFG_INDIS]) == 2'h0
    && $past(s.cfg_s2[`DPL_CFG_OUTDIS]) == 2'h0
    |-> s.cap_w[G +: `DPL_PIX_W]
      == depth_mask($past(pix_even_rgb_in), $past(depth)))
    else $error("even pixel not on second port");

  chk_depth_18: assert property (s.cap_v && $past(depth) == DPL_D18
    |-> (s.cap_w[3:0] | s.cap_w[13:10] | s.cap_w[23:20]) == 4'h0)
    else $error("low colour bits kept at 18-bit depth");

  chk_edge_fall: assert property (s.cap_v && $past(s.cfg_s2[`DPL_CFG_EDGE])
    |-> s.cap_w == $past(neg_w))
    else $error("falling edge sample not captured");

  chk_in_disable: assert property (s.cap_v && $past(s.cfg_s2[`DPL_CFG_INDIS][0])
    |-> s.cap_w[`DPL_PIX_W-1:0] == '0)
    else $error("disabled input channel passed data");

  chk_out_disable: assert property (s.cap_v && $past(s.cfg_s2[`DPL_CFG_OUTDIS][0])
    |-> s.cap_w[G-1:0] == '0)
    else $error("disabled output group carries data");

  chk_trim_delay: assert property (seq_trim2_cap
    |-> tap_v && tap_w == $past(s.cap_w, 2))
    else $error("trim tap misaligned");

  chk_swing_follow: assert property (seq_opt_steady
    |-> differential_swing_out == reduced_swing_in
      && offset_level_out == offset_level_in)
    else $error("swing or offset not applied");

  chk_push_room: assert property (tap_v && ce_in |-> fifo_wr_ready)
    else $error("word dropped at full buffer");

  chk_pop_req: assert property (fifo_pop |=> s.req != $past(s.req)
    && s.xfer_w == $past(fifo_rd_data))
    else $error("handoff word not launched");

  chk_hold_word: assert property (s.hs == DPL_HS_WAIT |=> $stable(s.xfer_w))
    else $error("handoff word changed while pending");

endmodule
`default_nettype wire

// ===== dv/dpl_rx_model.sv
// Purpose: panel receiver model that rebuilds seventy-bit words from the lanes
// Assumes: lanes and clock lane change just after the link clock rises
// Notes: frames are found from the clock lane pattern; zero frames pass as well
`timescale 1ns/100ps
`default_nettype none
`include "dpl_params.svh"
module dpl_rx_model
  import dpl_pkg::*;
(
  // Link clock and reset
  input wire logic link_clk_in,
  input wire logic nrst_in,
  // Lanes from the transmitter
  input wire logic [`DPL_GRP_LANES-1:0] first_port_lanes_in,
  input wire logic [`DPL_GRP_LANES-1:0] second_port_lanes_in,
  input wire logic link_clk_lane_in,
  // Rebuilt words
  output logic [`DPL_WORD_W-1:0] word_out,
  output logic strobe_out,
  output logic frame_err_out
);
  logic [6:0] lane_sr [`DPL_LANES];
  logic [6:0] ck_sr;
  logic [6:0] ck;
  logic [9:0] ln;
  logic locked;
  int gap;
  always @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ck_sr <= '0;
      locked <= 1'b0;
      gap <= 0;
      strobe_out <= 1'b0;
      frame_err_out <= 1'b0;
      word_out <= '0;
    end else begin
      ln = {second_port_lanes_in, first_port_lanes_in};
      ck = {ck_sr[5:0], link_clk_lane_in};
      ck_sr <= ck;
      strobe_out <= 1'b0;
      frame_err_out <= 1'b0;
      gap <= gap + 1;
      for (int k = 0; k < `DPL_LANES; k++) begin
        lane_sr[k] <= {lane_sr[k][5:0], ln[k]};
        // First bit of a slice lands at the top
        word_out[`DPL_LANE_BITS*k +: `DPL_LANE_BITS] <= {lane_sr[k][5:0], ln[k]};
      end
      if (ck == `DPL_CLK_LANE_PAT) begin
        strobe_out <= 1'b1;
        gap <= 0;
        locked <= 1'b1;
        frame_err_out <= locked && gap != 6;
      end else if (locked && gap >= 6) begin
        // A stretched frame means the lane rate slipped
        frame_err_out <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/dual_pixel_lvds_serializer_test.sv
// Purpose: self-checking bench of the lane transmitter core
// Assumes: option pins change only while no word is in flight
// Notes: all-zero frames are idle, so every test pixel keeps hsync high
`timescale 1ns/100ps
`default_nettype none
`include "dpl_params.svh"
module dual_pixel_lvds_serializer_test
  import dpl_pkg::*;
;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic pix_valid = 1'b0;
  logic [29:0] pix_odd = '0;
  logic [29:0] pix_even = '0;
  logic [4:0] ctl = '0;
  logic edge_sel = 1'b0;
  logic dual = 1'b0;
  logic swing = 1'b0;
  logic [1:0] depth = '0;
  logic [1:0] trim = '0;
  logic [1:0] indis = '0;
  logic [1:0] outdis = '0;
  logic [1:0] offs = '0;
  logic pix_ready;
  logic swing_q;
  logic [1:0] offs_q;
  logic [4:0] lanes_a;
  logic [4:0] lanes_b;
  logic ck_lane;
  logic [69:0] rx_word;
  logic rx_strobe;
  logic frame_err;
  logic [69:0] exp_q [$];
  logic [9:0] seq = 10'h001;
  logic saw_busy = 1'b0;
  logic chk_frames = 1'b1;
  int n_errors = 0;
  int n_compared = 0;

  always #50 clk = ~clk;
  initial begin
    #37;
    forever #80 link_clk = ~link_clk;
  end

  dpl_tx_core dut (
    .clk_in(clk), .nrst_in(nrst), .ce_in(ce), .link_clk_in(link_clk),
    .pix_valid_in(pix_valid), .pix_ready_out(pix_ready),
    .pix_odd_rgb_in(pix_odd), .pix_even_rgb_in(pix_even),
    .hsync_in(ctl[0]), .vsync_in(ctl[1]), .data_enable_in(ctl[2]), .user_ctl_in(ctl[4:3]),
    .capture_edge_select_in(edge_sel), .dual_pixel_in(dual), .depth_sel_in(depth),
    .setup_trim_in(trim), .in_chan_disable_in(indis), .out_chan_disable_in(outdis),
    .reduced_swing_in(swing), .offset_level_in(offs),
    .first_port_lanes_out(lanes_a), .second_port_lanes_out(lanes_b),
    .link_clk_lane_out(ck_lane), .differential_swing_out(swing_q), .offset_level_out(offs_q)
  );

  dpl_rx_model rx (
    .link_clk_in(link_clk), .nrst_in(nrst), .first_port_lanes_in(lanes_a),
    .second_port_lanes_in(lanes_b), .link_clk_lane_in(ck_lane),
    .word_out(rx_word), .strobe_out(rx_strobe), .frame_err_out(frame_err)
  );

  task automatic miss(string s);
    n_errors++;
    $display("mismatch at %0t: %s", $time, s);
  endtask

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic [69:0] exp_word(logic [29:0] o, logic [29:0] e, logic [4:0] c);
    logic [9:0] m;
    logic [34:0] go;
    logic [34:0] ge;
    m = depth == 2'h1 ? `DPL_MASK_24 : depth == 2'h2 ? `DPL_MASK_18 : `DPL_MASK_30;
    go = {c, indis[0] ? 30'h0 : (o & {m, m, m})};
    ge = {c, indis[1] ? 30'h0 : (e & {m, m, m})};
    if (outdis[0]) go = '0;
    if (outdis[1] || !dual) ge = '0;
    return {ge, go};
  endfunction

  // Offers n pixels back to back, holding each until a cycle with ready high
  task automatic send(int n);
    int i;
    int k;
    logic [29:0] o;
    logic [29:0] e;
    logic [4:0] c;
    logic [69:0] w;
    i = 0;
    k = 0;
    while (i < n && k < 2000) begin
      @(negedge clk);
      k++;
      if (pix_ready === 1'b1) begin
        o = {seq, ~seq, seq ^ 10'h2a5};
        e = {~seq, seq ^ 10'h15a, seq};
        c = {seq[3:0], 1'b1};
        pix_odd <= o;
        pix_even <= e;
        ctl <= c;
        pix_valid <= 1'b1;
        w = exp_word(o, e, c);
        // All-zero frames look idle on the lanes, so none is expected
        if (w != '0) exp_q.push_back(w);
        seq++;
        i++;
      end else begin
        pix_valid <= 1'b0;
      end
    end
    @(negedge clk);
    pix_valid <= 1'b0;
  endtask

  task automatic test(string name, logic e, logic d, logic [1:0] dp, logic [1:0] tr,
                      logic [1:0] id, logic [1:0] od, int n);
    int k;
    @(negedge clk);
    edge_sel <= e;
    dual <= d;
    depth <= dp;
    trim <= tr;
    indis <= id;
    outdis <= od;
    // Option pins pass a two-stage sync before they act
    repeat (6) @(negedge clk);
    send(n);
    k = 0;
    while (exp_q.size() != 0 && k < 1000) begin
      @(posedge clk);
      k++;
    end
    n_compared++;
    if (exp_q.size() != 0) miss("words missing");
    repeat (40) @(posedge clk);
    $display("test %s done, errors %0d", name, n_errors);
  endtask

  always @(posedge link_clk) begin
    if (chk_frames && frame_err === 1'b1) miss("clock lane framing");
    if (rx_strobe === 1'b1 && rx_word !== '0) begin
      n_compared++;
      if (exp_q.size() == 0) miss("unexpected word");
      else if (rx_word !== exp_q[0]) miss("word differs");
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end

  always @(negedge clk) begin
    if (pix_ready === 1'b0) saw_busy = 1'b1;
  end

  // Tests take well under half a millisecond; the limit leaves wide margin
  initial begin
    #3_000_000;
    miss("watchdog");
    end_sim();
  end

  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    test("single", 0, 0, 2'h0, 2'h0, 2'h0, 2'h0, 3);
    test("dual", 0, 1, 2'h0, 2'h0, 2'h0, 2'h0, 3);
    for (int i = 0; i < 4; i++) begin
      test("depth", 0, 1, 2'(i), 2'h0, 2'h0, 2'h0, 2);
      test("trim", 0, 1, 2'h0, 2'(i), 2'h0, 2'h0, 2);
    end
    test("falling edge", 1, 1, 2'h0, 2'h0, 2'h0, 2'h0, 3);
    test("inputs off", 0, 1, 2'h0, 2'h0, 2'h3, 2'h0, 2);
    test("odd out off", 0, 1, 2'h0, 2'h0, 2'h0, 2'h1, 2);
    test("all out off", 0, 1, 2'h0, 2'h0, 2'h0, 2'h3, 2);
    test("single even off", 0, 0, 2'h2, 2'h0, 2'h2, 2'h0, 2);
    saw_busy = 1'b0;
    test("burst", 0, 1, 2'h1, 2'h0, 2'h1, 2'h0, 20);
    n_compared++;
    if (saw_busy !== 1'b1) miss("buffer never refused");
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      swing <= i[1];
      offs <= 2'(i);
      repeat (5) @(negedge clk);
      n_compared++;
      if (swing_q !== i[1] || offs_q !== 2'(i)) miss("swing or offset");
    end
    $display("test swing and offset done, errors %0d", n_errors);
    // Frozen core may stretch one frame, so framing is not judged here
    @(negedge clk);
    chk_frames = 1'b0;
    ce <= 1'b0;
    pix_valid <= 1'b1;
    repeat (2) @(negedge clk);
    pix_valid <= 1'b0;
    ce <= 1'b1;
    repeat (60) @(posedge clk);
    chk_frames = 1'b1;
    $display("test clock enable done, errors %0d", n_errors);
    end_sim();
  end
endmodule
`default_nettype wire
